// ### hw/ltsr_defines.vh
`ifndef LTSR_DEFINES_VH
`define LTSR_DEFINES_VH

// training state code presented by each lane's training state machine
`define LTSR_ST_W 2
`define LTSR_ST_IDLE 2'h0
`define LTSR_ST_TRAIN 2'h1
`define LTSR_ST_DATA 2'h2
`define LTSR_ST_FAIL 2'h3

// received control and status block layout
`define LTSR_BLK_W 16
`define LTSR_CTL_PRESET 13
`define LTSR_CTL_INIT 12
`define LTSR_FLD_P1 5:4
`define LTSR_FLD_K0 3:2
`define LTSR_FLD_M1 1:0

// apb map, byte addresses
`define LTSR_ADDR_W 8
`define LTSR_OFF_CTRL 8'h00
`define LTSR_OFF_STATUS 8'h04
`define LTSR_OFF_FIELDS 8'h10
`define LTSR_OFF_COUNT 8'h20
`define LTSR_BANK_MASK 8'hf0
`define LTSR_LANE_SEL 3:2
`define LTSR_CTRL_RESET 4'hf

// frame lock hysteresis, in training frames
`define LTSR_LOCK_GOOD 3'h4
`define LTSR_LOCK_BAD 3'h3
`define LTSR_CNT_W 16

`endif

// ### hw/ltsr_lane_fields.v
`include "ltsr_defines.vh"

module ltsr_lane_fields (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // received frame
  input wire capture,
  input wire [`LTSR_BLK_W-1:0] ctl_word,
  input wire [`LTSR_BLK_W-1:0] stat_word,
  // held partner fields
  output reg preset_req,
  output reg init_req,
  output reg [1:0] post_req,
  output reg [1:0] main_req,
  output reg [1:0] pre_req,
  output reg [1:0] post_stat,
  output reg [1:0] main_stat,
  output reg [1:0] pre_stat
);

  // fields only move on a checked frame and hold in between, so software
  // never sees a half-decoded or corrupted block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_req <= 1'b0;
      init_req <= 1'b0;
      post_req <= 2'h0;
      main_req <= 2'h0;
      pre_req <= 2'h0;
      post_stat <= 2'h0;
      main_stat <= 2'h0;
      pre_stat <= 2'h0;
    end else if (capture) begin
      preset_req <= ctl_word[`LTSR_CTL_PRESET];
      init_req <= ctl_word[`LTSR_CTL_INIT];
      post_req <= ctl_word[`LTSR_FLD_P1];
      main_req <= ctl_word[`LTSR_FLD_K0];
      pre_req <= ctl_word[`LTSR_FLD_M1];
      post_stat <= stat_word[`LTSR_FLD_P1];
      main_stat <= stat_word[`LTSR_FLD_K0];
      pre_stat <= stat_word[`LTSR_FLD_M1];
    end
  end

endmodule

// ### hw/ltsr_top.v
// What this block does
// - per lane, training-done high while the training machine sends data.
// - per lane, training-active high while the lane is training.
// - per lane, timeout high when the training machine reports a timeout.
// - per lane, frame-start high exactly one cycle per received frame.
// - after training starts, frame-locked high once frames synchronise.
// - per lane, show the partner's preset request bit.
// - per lane, show the partner's initialize request bit.
// - per lane, show the partner's 2-bit post-cursor update request.
// - per lane, show the partner's 2-bit main-cursor update request.
// - per lane, show the partner's 2-bit pre-cursor update request.
// - per lane, show the partner's 2-bit post-cursor update status.
// - per lane, show the partner's 2-bit main-cursor update status.
// - per lane, show the partner's 2-bit pre-cursor update status.
// - single output follows the recovery hold from auto-negotiation.
`include "ltsr_defines.vh"

module ltsr_top #(
  parameter LANES = 4,
  parameter LOCK_W = 3,
  parameter [LOCK_W-1:0] LOCK_GOOD = `LTSR_LOCK_GOOD,
  parameter [LOCK_W-1:0] LOCK_BAD = `LTSR_LOCK_BAD
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`LTSR_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // per-lane training state machines
  input wire [LANES*`LTSR_ST_W-1:0] lt_state,
  // per-lane training frame receivers
  input wire [LANES-1:0] rx_frame_marker,
  input wire [LANES-1:0] rx_frame_end,
  input wire [LANES-1:0] rx_frame_good,
  input wire [LANES*`LTSR_BLK_W-1:0] rx_ctl_word,
  input wire [LANES*`LTSR_BLK_W-1:0] rx_stat_word,
  // auto-negotiation
  input wire an_recovery_hold,
  // training status
  output reg [LANES-1:0] lane_training_done,
  output reg [LANES-1:0] lane_training_active,
  output reg [LANES-1:0] lane_training_timeout,
  output reg [LANES-1:0] rx_training_frame_start,
  output wire [LANES-1:0] rx_training_frame_locked,
  // partner request fields
  output wire [LANES-1:0] partner_preset_request,
  output wire [LANES-1:0] partner_init_request,
  output wire [LANES*2-1:0] partner_post_cursor_request,
  output wire [LANES*2-1:0] partner_main_cursor_request,
  output wire [LANES*2-1:0] partner_pre_cursor_request,
  // partner status fields
  output wire [LANES*2-1:0] partner_post_cursor_status,
  output wire [LANES*2-1:0] partner_main_cursor_status,
  output wire [LANES*2-1:0] partner_pre_cursor_status,
  // recovery hold
  output reg rx_recovery_hold
);

  localparam LK_HUNT = 3'b001;
  localparam LK_CHECK = 3'b010;
  localparam LK_LOCKED = 3'b100;

  function [1:0] pick2;
    input [LANES*2-1:0] vec;
    input [1:0] lane;
    begin
      pick2 = vec[lane*2 +: 2];
    end
  endfunction

  function bank_hit;
    input [`LTSR_ADDR_W-1:0] addr;
    input [`LTSR_ADDR_W-1:0] base;
    begin
      bank_hit = ((addr & `LTSR_BANK_MASK) == base);
    end
  endfunction

  // apb decode
  wire setup = psel & ~penable;
  wire wr_access = psel & penable & pwrite;
  wire [1:0] sel_lane = paddr[`LTSR_LANE_SEL];
  wire hit_ctrl = (paddr == `LTSR_OFF_CTRL);
  wire hit_status = (paddr == `LTSR_OFF_STATUS);
  wire hit_fields = bank_hit(paddr, `LTSR_OFF_FIELDS) && (paddr[1:0] == 2'h0);
  wire hit_count = bank_hit(paddr, `LTSR_OFF_COUNT) && (paddr[1:0] == 2'h0);
  wire hit_any = hit_ctrl | hit_status | hit_fields | hit_count;

  // lane enable; a disabled lane never locks and never captures fields
  reg [LANES-1:0] lane_en;
  reg [`LTSR_CNT_W-1:0] frame_count [0:LANES-1];
  reg [LANES-1:0] marker_q;
  reg [31:0] next_prdata;

  wire [LANES-1:0] lane_locked;
  wire [LANES-1:0] capture;

  // zero wait states: data is prepared in the setup cycle
  assign pready = psel & penable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_en <= `LTSR_CTRL_RESET;
    end else if (wr_access && hit_ctrl) begin
      lane_en <= pwdata[LANES-1:0];
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_prdata[LANES-1:0] = lane_en;
    end else if (hit_status) begin
      next_prdata = {15'h0000, rx_recovery_hold,
                     rx_training_frame_locked, lane_training_timeout,
                     lane_training_active, lane_training_done};
    end else if (hit_fields) begin
      next_prdata = {18'h00000,
                     pick2(partner_post_cursor_status, sel_lane),
                     pick2(partner_main_cursor_status, sel_lane),
                     pick2(partner_pre_cursor_status, sel_lane),
                     pick2(partner_post_cursor_request, sel_lane),
                     pick2(partner_main_cursor_request, sel_lane),
                     pick2(partner_pre_cursor_request, sel_lane),
                     partner_init_request[sel_lane],
                     partner_preset_request[sel_lane]};
    end else if (hit_count) begin
      next_prdata[`LTSR_CNT_W-1:0] = frame_count[sel_lane];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      // unmapped addresses and writes to read-only words are refused
      pslverr <= ~hit_any | (pwrite & hit_status) | (pwrite & hit_fields);
    end
  end

  // status straight from the training state codes
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_training_done <= {LANES{1'b0}};
      lane_training_active <= {LANES{1'b0}};
      lane_training_timeout <= {LANES{1'b0}};
      rx_training_frame_start <= {LANES{1'b0}};
      marker_q <= {LANES{1'b0}};
      rx_recovery_hold <= 1'b0;
    end else begin
      for (k = 0; k < LANES; k = k + 1) begin
        lane_training_done[k] <= (lt_state[k*`LTSR_ST_W +: `LTSR_ST_W] == `LTSR_ST_DATA);
        lane_training_active[k] <= (lt_state[k*`LTSR_ST_W +: `LTSR_ST_W] == `LTSR_ST_TRAIN);
        lane_training_timeout[k] <= (lt_state[k*`LTSR_ST_W +: `LTSR_ST_W] == `LTSR_ST_FAIL);
      end
      // edge of the marker, so a held marker still yields a single pulse
      marker_q <= rx_frame_marker;
      rx_training_frame_start <= rx_frame_marker & ~marker_q;
      rx_recovery_hold <= an_recovery_hold;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      wire [`LTSR_ST_W-1:0] st = lt_state[g*`LTSR_ST_W +: `LTSR_ST_W];
      wire started = (st != `LTSR_ST_IDLE);
      wire good = rx_frame_end[g] & rx_frame_good[g];
      wire bad = rx_frame_end[g] & ~rx_frame_good[g];
      wire cnt_clr = wr_access && hit_count && (sel_lane == g);
      reg [2:0] lk_state;
      reg [2:0] next_lk_state;
      reg [LOCK_W-1:0] run;
      reg [LOCK_W-1:0] next_run;

      always @* begin
        next_lk_state = lk_state;
        next_run = run;
        case (lk_state)
          LK_HUNT: begin
            next_run = {LOCK_W{1'b0}};
            if (good) begin
              next_lk_state = LK_CHECK;
              next_run = {{(LOCK_W-1){1'b0}}, 1'b1};
            end
          end
          LK_CHECK: begin
            if (bad) begin
              next_lk_state = LK_HUNT;
              next_run = {LOCK_W{1'b0}};
            end else if (good) begin
              next_run = run + {{(LOCK_W-1){1'b0}}, 1'b1};
              if (next_run == LOCK_GOOD) begin
                next_lk_state = LK_LOCKED;
                next_run = {LOCK_W{1'b0}};
              end
            end
          end
          LK_LOCKED: begin
            if (good) begin
              next_run = {LOCK_W{1'b0}};
            end else if (bad) begin
              next_run = run + {{(LOCK_W-1){1'b0}}, 1'b1};
              if (next_run == LOCK_BAD) begin
                next_lk_state = LK_HUNT;
                next_run = {LOCK_W{1'b0}};
              end
            end
          end
          default: begin
            next_lk_state = LK_HUNT;
            next_run = {LOCK_W{1'b0}};
          end
        endcase
        // lock is only meaningful once training has begun
        if (!started || !lane_en[g]) begin
          next_lk_state = LK_HUNT;
          next_run = {LOCK_W{1'b0}};
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lk_state <= LK_HUNT;
          run <= {LOCK_W{1'b0}};
        end else begin
          lk_state <= next_lk_state;
          run <= next_run;
        end
      end

      assign lane_locked[g] = (lk_state == LK_LOCKED);
      assign rx_training_frame_locked[g] = lane_locked[g];
      // a good frame while locked is the only source of new fields
      assign capture[g] = good & lane_locked[g] & lane_en[g];

      // saturating count of captured frames (good, locked, lane enabled); a frame landing on the clear counts
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          frame_count[g] <= {`LTSR_CNT_W{1'b0}};
        end else if (cnt_clr) begin
          frame_count[g] <= {{(`LTSR_CNT_W-1){1'b0}}, capture[g]};
        end else if (capture[g] && (frame_count[g] != {`LTSR_CNT_W{1'b1}})) begin
          frame_count[g] <= frame_count[g] + {{(`LTSR_CNT_W-1){1'b0}}, 1'b1};
        end
      end

      ltsr_lane_fields u_fields (
        .pclk(pclk),
        .presetn(presetn),
        .capture(capture[g]),
        .ctl_word(rx_ctl_word[g*`LTSR_BLK_W +: `LTSR_BLK_W]),
        .stat_word(rx_stat_word[g*`LTSR_BLK_W +: `LTSR_BLK_W]),
        .preset_req(partner_preset_request[g]),
        .init_req(partner_init_request[g]),
        .post_req(partner_post_cursor_request[g*2 +: 2]),
        .main_req(partner_main_cursor_request[g*2 +: 2]),
        .pre_req(partner_pre_cursor_request[g*2 +: 2]),
        .post_stat(partner_post_cursor_status[g*2 +: 2]),
        .main_stat(partner_main_cursor_status[g*2 +: 2]),
        .pre_stat(partner_pre_cursor_status[g*2 +: 2])
      );
    end
  endgenerate

endmodule

// ### sim/ltsr_partner.sv
module ltsr_partner (
  // clock
  input wire pclk,
  // training frames toward the block
  output logic [3:0] marker,
  output logic [3:0] fend,
  output logic [3:0] good,
  output logic [63:0] ctl,
  output logic [63:0] stat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {marker, fend, good, ctl, stat} = '0;
  // words flip after the frame so a stale block can never look valid
  task automatic send(input int l, input logic ok, input logic [15:0] c, input logic [15:0] s);
    @(posedge pclk);
    marker[l] <= 1'h1;
    @(posedge pclk);
    marker[l] <= 1'h0;
    fend[l] <= 1'h1;
    good[l] <= ok;
    ctl[16*l+:16] <= c;
    stat[16*l+:16] <= s;
    @(posedge pclk);
    fend[l] <= 1'h0;
    good[l] <= 1'h0;
    ctl[16*l+:16] <= ~c;
    stat[16*l+:16] <= ~s;
  endtask
endmodule

// ### sim/ltsr_sva.sv
`include "ltsr_defines.vh"
module ltsr_sva #(parameter LANES = 4) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // lane inputs
  input wire [LANES*`LTSR_ST_W-1:0] lt_state,
  input wire [LANES-1:0] rx_frame_marker,
  input wire [LANES-1:0] rx_frame_end,
  input wire [LANES-1:0] rx_frame_good,
  input wire [LANES*`LTSR_BLK_W-1:0] rx_ctl_word,
  input wire [LANES*`LTSR_BLK_W-1:0] rx_stat_word,
  input wire an_recovery_hold,
  // watched outputs
  input wire [LANES-1:0] lane_training_done,
  input wire [LANES-1:0] lane_training_active,
  input wire [LANES-1:0] lane_training_timeout,
  input wire [LANES-1:0] rx_training_frame_start,
  input wire [LANES-1:0] rx_training_frame_locked,
  input wire rx_recovery_hold,
  input wire [LANES-1:0] partner_preset_request,
  input wire [LANES-1:0] partner_init_request,
  input wire [LANES*2-1:0] partner_post_cursor_request,
  input wire [LANES*2-1:0] partner_pre_cursor_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [LANES-1:0] st_data, st_train, st_fail;
  wire [5:0] seen0 = {partner_preset_request[0], partner_init_request[0], partner_post_cursor_request[1:0],
    partner_pre_cursor_status[1:0]};
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      st_data[i] = lt_state[2*i+:2] == `LTSR_ST_DATA;
      st_train[i] = lt_state[2*i+:2] == `LTSR_ST_TRAIN;
      st_fail[i] = lt_state[2*i+:2] == `LTSR_ST_FAIL;
    end
  end
  sequence good0;
    rx_frame_end[0] && rx_frame_good[0];
  endsequence
  sequence took0;
    seen0 == $past({rx_ctl_word[13:12], rx_ctl_word[5:4], rx_stat_word[1:0]});
  endsequence
  done_decode_a: assert property (lane_training_done == $past(st_data)) else $error("done wrong");
  active_decode_a: assert property (lane_training_active == $past(st_train)) else $error("active wrong");
  timeout_decode_a: assert property (lane_training_timeout == $past(st_fail)) else $error("timeout wrong");
  frame_start_a:
    assert property (rx_training_frame_start == ($past(rx_frame_marker) & ~$past(rx_frame_marker, 2)))
    else $error("frame start wrong");
  lock_gain_a: assert property ($rose(rx_training_frame_locked[0]) |->
    $past(rx_frame_end[0] && rx_frame_good[0])) else $error("lock without frame");
  lock_idle_a: assert property (lt_state[1:0] == `LTSR_ST_IDLE |=> !rx_training_frame_locked[0])
    else $error("lock while idle");
  fields_take_a: assert property (good0 ##0 rx_training_frame_locked[0] |=> took0)
    else $error("field not taken");
  fields_hold_a: assert property (!$past(rx_frame_end[0]) |-> $stable(seen0)) else $error("field moved");
  hold_copy_a: assert property (rx_recovery_hold == $past(an_recovery_hold)) else $error("hold wrong");
endmodule

bind ltsr_top ltsr_sva #(.LANES(LANES)) ltsr_sva_i (.*);

// ### sim/tb_top.sv
`include "ltsr_defines.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, an_recovery_hold = 1'h0;
  logic [7:0] paddr = 8'h00, lt_state = 8'h00, st;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] c, s;
  logic err;
  int errors = 0, total_checks = 0, sofs = 0;
  wire [3:0] sof;
  wire pready, pslverr, rhold;
  wire [31:0] prdata;
  wire [3:0] mk, fe, fg, done, act, tmo, lck, pre_r, ini_r;
  wire [63:0] cw, sw;
  wire [7:0] pq, mq, rq, ps, ms, rs;
  always #20 pclk = ~pclk;
  // counts high cycles, so a stretched frame-start pulse shows up as an extra count
  always @(posedge pclk) sofs <= sofs + $countones(sof);
  ltsr_partner ltsr_partner_i (.pclk, .marker(mk), .fend(fe), .good(fg), .ctl(cw), .stat(sw));
  ltsr_top ltsr_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .lt_state, .rx_frame_marker(mk), .rx_frame_end(fe), .rx_frame_good(fg), .rx_ctl_word(cw), .rx_stat_word(sw),
    .an_recovery_hold, .lane_training_done(done), .lane_training_active(act), .lane_training_timeout(tmo),
    .rx_training_frame_start(sof), .rx_training_frame_locked(lck), .partner_preset_request(pre_r),
    .partner_init_request(ini_r), .partner_post_cursor_request(pq), .partner_main_cursor_request(mq),
    .partner_pre_cursor_request(rq), .partner_post_cursor_status(ps), .partner_main_cursor_status(ms),
    .partner_pre_cursor_status(rs), .rx_recovery_hold(rhold));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // zero-wait slave, but the wait stays bounded in case pready never comes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK("prdata", e, rd)
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk(`LTSR_OFF_CTRL, 32'h0000000f);
    rd_chk(`LTSR_OFF_STATUS, 32'h0);
    rd_chk(8'h40, 32'h0);
    `CHK("unmapped_err", 1'h1, err)
    apb(1'h1, `LTSR_OFF_STATUS, 32'hffffffff);
    `CHK("ro_write_err", 1'h1, err)
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      for (int l = 0; l < 4; l++) st[2*l+:2] = 2'(l + k);
      @(posedge pclk);
      lt_state <= st;
      an_recovery_hold <= k[0];
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      `CHK("recovery_hold", k[0], rhold)
      for (int l = 0; l < 4; l++) begin
        `CHK("state", {st[2*l+:2] == 2'h2, st[2*l+:2] == 2'h1, st[2*l+:2] == 2'h3}, {done[l], act[l], tmo[l]})
      end
    end
    $display("test state decode done");
    @(posedge pclk);
    lt_state <= 8'h55;
    an_recovery_hold <= 1'h0;
    for (int l = 0; l < 4; l++) begin
      c = {2'h0, l[0], ~l[0], 6'h0, 6'h1b ^ 6'(l)};
      s = {10'h0, 6'h24 ^ 6'(l)};
      repeat (4) ltsr_partner_i.send(l, 1'h1, 16'h3fff, 16'h003f);
      @(negedge pclk);
      `CHK("locked", 1'h1, lck[l])
      `CHK("pre_lock", 2'h0, pq[2*l+:2])
      ltsr_partner_i.send(l, 1'h1, c, s);
      @(negedge pclk);
      `CHK("req", {c[13:12], c[5:0]}, {pre_r[l], ini_r[l], pq[2*l+:2], mq[2*l+:2], rq[2*l+:2]})
      `CHK("stat", s[5:0], {ps[2*l+:2], ms[2*l+:2], rs[2*l+:2]})
      ltsr_partner_i.send(l, 1'h0, ~c, ~s);
      @(negedge pclk);
      `CHK("bad_frame", c[5:0], {pq[2*l+:2], mq[2*l+:2], rq[2*l+:2]})
    end
    `CHK("frame_starts", 24, sofs)
    $display("test frames done");
    rd_chk(`LTSR_OFF_STATUS, 32'h0000f0f0);
    rd_chk(8'h1c, {18'h0, s[5:0], c[5:0], c[12], c[13]});
    rd_chk(`LTSR_OFF_COUNT, 32'h1);
    apb(1'h1, `LTSR_OFF_COUNT, 32'h0);
    `CHK("count_clr_err", 1'h0, err)
    rd_chk(`LTSR_OFF_COUNT, 32'h0);
    apb(1'h1, `LTSR_OFF_FIELDS, 32'hffffffff);
    `CHK("fields_ro_err", 1'h1, err)
    apb(1'h1, `LTSR_OFF_CTRL, 32'h5);
    rd_chk(`LTSR_OFF_CTRL, 32'h5);
    `CHK("lane_off", 4'h5, lck)
    @(posedge pclk);
    lt_state <= 8'h00;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    `CHK("idle_unlock", 4'h0, lck)
    $display("test control done");
    complete_run();
  end
endmodule
